// >>> common/sbg_pkg.sv
/*
 * constants for the baud generator and multiprocessor bit block:
 * register byte offsets, field positions, reset values, divide counts.
 * assumes a 32-bit APB with byte addresses, one word per register.
 */
package sbg_pkg;
   // register byte offsets
   localparam logic [7:0] MODE_OFS = 8'h00;
   localparam logic [7:0] CTRL_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] DIV_OFS = 8'h0C;
   localparam logic [7:0] RXD_OFS = 8'h10;
   // mode register fields
   localparam int MODE_PS_LO = 0;
   localparam int MODE_PS_HI = 1;
   localparam int MODE_MP = 2;
   localparam int MODE_SYNC = 7;
   // control register fields
   localparam int CTRL_TE = 0;
   localparam int CTRL_RE = 1;
   // status register fields
   localparam int STAT_TXMP = 0;
   localparam int STAT_RXMP = 1;
   localparam int STAT_RXAV = 2;
   localparam int STAT_FAST = 3;
   // receive data register fields
   localparam int RXD_MP = 8;
   // reset values
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [7:0] DIV_RST = 8'hFF;
   localparam logic RXMP_RST = 1'b0;
   localparam logic TXMP_RST = 1'b0;
   // generator ticks per bit and per oversample
   localparam logic [5:0] ASYNC_BIT_LAST = 6'h3F;
   localparam logic [5:0] SYNC_BIT_LAST = 6'h07;
   localparam logic [1:0] OVS_LAST = 2'h3;
   // receive buffer shape
   localparam int RXF_WIDTH = 9;
   localparam int RXF_DEPTH = 16;
endpackage

// >>> design/sbg_baud_gen_mpb.sv
/*
 * serial baud rate generator with multiprocessor bit handling,
 * divisor and mode registers on APB, received words buffered in a fifo.
 * assumes the receive and transmit shifters sit outside, fed by the
 * ticks and mode outputs here, all on ref_clk.
 */
// Functional notes
// - the multiprocessor bit of each received multiprocessor character is captured into a read-only flag.
// - clearing receive enable leaves that flag unchanged; it resets to zero.
// - in multiprocessor format the software transmit bit is sent as each character's multiprocessor bit; it resets to zero.
// - the transmit bit is ignored in synchronous mode, without multiprocessor format, or with transmit disabled.
// - an 8-bit divisor register is readable and writable at any time.
// - the divisor becomes all ones on reset and on entry to any low-power state.
// - a 2-bit select divides the clock feeding the generator by 1, 4, 16 or 64.
// - in asynchronous mode the bit rate is clock over 64, over four to the select, over divisor plus one.
// - in synchronous mode the bit rate is clock over 8, over four to the select, over divisor plus one.
// - every divisor from 0 to 255 and every select from 0 to 3 is a valid setting.
// - synchronous mode at select 0 and divisor 0 only guarantees isolated characters.
module sbg_baud_gen_mpb #(
   parameter int RXF_WIDTH = sbg_pkg::RXF_WIDTH,
   parameter int RXF_DEPTH = sbg_pkg::RXF_DEPTH
) (
   input wire logic ref_clk, // system clock, 250 MHz
   input wire logic nrst, // async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped
   input wire logic lowpwr_enter, // low-power state entry
   input wire logic rx_valid, // received character valid
   output logic rx_ready, // receive buffer has room
   input wire logic [7:0] rx_data, // received character
   input wire logic rx_mpb, // received multiproc bit
   output logic tx_mpb, // multiproc bit to append
   output logic tx_mpb_used, // append a multiproc bit
   output logic sync_mode, // synchronous mode selected
   output logic multiproc_en, // multiprocessor format
   output logic transmit_enable, // transmitter enabled
   output logic receive_enable, // receiver enabled
   output logic brg_tick, // generator tick
   output logic sample_tick, // async 16x oversample
   output logic bit_tick, // one per bit period
   output logic cont_xfer_blocked // fastest sync setting
);
   localparam int LW = $clog2(RXF_DEPTH) + 1;
   localparam logic [LW-1:0] RXF_FULL = LW'(RXF_DEPTH);

   // register state
   logic [7:0] serial_mode_reg_q;
   logic [7:0] serial_mode_reg_d;
   logic [1:0] ctrl_q;
   logic [1:0] ctrl_d;
   logic [7:0] bit_rate_divisor_q;
   logic [7:0] bit_rate_divisor_d;
   logic rx_multiproc_bit_q;
   logic rx_multiproc_bit_d;
   logic tx_multiproc_bit_q;
   logic tx_multiproc_bit_d;

   // bus answer state
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pready_q;
   logic pready_d;
   logic pslverr_q;
   logic pslverr_d;
   logic rxd_hit_q;
   logic rxd_hit_d;

   // output and timing state
   logic rx_ready_q;
   logic rx_ready_d;
   logic tx_mpb_q;
   logic tx_mpb_d;
   logic tx_mpb_used_q;
   logic tx_mpb_used_d;
   logic [5:0] sub_q;
   logic [5:0] sub_d;
   logic sample_tick_q;
   logic sample_tick_d;
   logic bit_tick_q;
   logic bit_tick_d;
   logic fast_q;
   logic fast_d;

   // bus decode
   logic setup;
   logic acc_done;
   logic wr_en;
   logic rd_en;
   logic sel_mode;
   logic sel_ctrl;
   logic sel_stat;
   logic sel_div;
   logic sel_rxd;
   logic mapped;
   logic wr_mode;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_div;
   logic [31:0] rd_word;

   // field views
   logic [1:0] ps_sel;
   logic is_sync;
   logic is_mp;
   logic te;
   logic re;
   logic async_mp;

   // receive path
   logic rxf_in_ready;
   logic rxf_out_valid;
   logic [RXF_WIDTH-1:0] rxf_out_data;
   logic [LW-1:0] rxf_level;
   logic [LW-1:0] lvl_nx;
   logic push;
   logic pop;

   // generator
   logic gen_tick;
   logic restart;
   logic [5:0] bit_last;
   logic sub_wrap;

   assign ps_sel = {serial_mode_reg_q[sbg_pkg::MODE_PS_HI],
                    serial_mode_reg_q[sbg_pkg::MODE_PS_LO]};
   assign is_sync = serial_mode_reg_q[sbg_pkg::MODE_SYNC];
   assign is_mp = serial_mode_reg_q[sbg_pkg::MODE_MP];
   assign te = ctrl_q[sbg_pkg::CTRL_TE];
   assign re = ctrl_q[sbg_pkg::CTRL_RE];
   assign async_mp = !is_sync & is_mp;

   // APB: answer registered in setup, zero-wait access phase
   assign setup = psel & !penable;
   assign acc_done = psel & penable & pready_q;
   assign wr_en = acc_done & pwrite;
   assign rd_en = acc_done & !pwrite;
   assign sel_mode = (paddr == sbg_pkg::MODE_OFS);
   assign sel_ctrl = (paddr == sbg_pkg::CTRL_OFS);
   assign sel_stat = (paddr == sbg_pkg::STAT_OFS);
   assign sel_div = (paddr == sbg_pkg::DIV_OFS);
   assign sel_rxd = (paddr == sbg_pkg::RXD_OFS);
   assign mapped = sel_mode | sel_ctrl | sel_stat | sel_div | sel_rxd;
   assign wr_mode = wr_en & sel_mode & !pslverr_q;
   assign wr_ctrl = wr_en & sel_ctrl & !pslverr_q;
   assign wr_stat = wr_en & sel_stat & !pslverr_q;
   assign wr_div = wr_en & sel_div & !pslverr_q;

   assign rd_word =
      sel_mode ? {24'h00_0000, serial_mode_reg_q} :
      sel_ctrl ? {30'h0000_0000, ctrl_q} :
      sel_stat ? {28'h000_0000, fast_q, rxf_out_valid,
                  rx_multiproc_bit_q, tx_multiproc_bit_q} :
      sel_div ? {24'h00_0000, bit_rate_divisor_q} :
      (sel_rxd & rxf_out_valid) ?
         {{(32 - RXF_WIDTH){1'b0}}, rxf_out_data} :
      32'h0000_0000;

   assign pready_d = setup;
   assign pslverr_d = setup & !mapped;
   assign prdata_d = (setup & !pwrite) ? rd_word : prdata_q;

   // register writes
   assign serial_mode_reg_d = wr_mode ? pwdata[7:0] : serial_mode_reg_q;
   assign ctrl_d = wr_ctrl ? {pwdata[sbg_pkg::CTRL_RE],
                              pwdata[sbg_pkg::CTRL_TE]} : ctrl_q;
   assign tx_multiproc_bit_d = wr_stat ? pwdata[sbg_pkg::STAT_TXMP]
                                       : tx_multiproc_bit_q;
   assign bit_rate_divisor_d =
      lowpwr_enter ? sbg_pkg::DIV_RST :
      wr_div ? pwdata[7:0] : bit_rate_divisor_q;

   // receive buffer: ready is registered from the next level
   assign push = rx_valid & rx_ready_q & rxf_in_ready;
   // pop only a word that the setup cycle really returned
   assign rxd_hit_d = setup & !pwrite & sel_rxd & rxf_out_valid;
   assign pop = rd_en & rxd_hit_q;
   assign lvl_nx = LW'(rxf_level + push - pop);
   assign rx_ready_d = re & (lvl_nx != RXF_FULL);

   // status writes never reach the received flag; receive enable
   // dropping leaves it as it was
   assign rx_multiproc_bit_d = (push & async_mp) ? rx_mpb
                                                 : rx_multiproc_bit_q;

   // transmit multiproc bit only in async multiproc with te
   assign tx_mpb_used_d = async_mp & te;
   assign tx_mpb_d = tx_multiproc_bit_q & async_mp & te;

   // generator ticks subdivided per bit: 64 async, 8 sync
   assign restart = wr_div | wr_mode | lowpwr_enter;
   assign bit_last = is_sync ? sbg_pkg::SYNC_BIT_LAST
                             : sbg_pkg::ASYNC_BIT_LAST;
   assign sub_wrap = (sub_q == bit_last);
   assign sub_d = restart ? 6'h00 :
                  !gen_tick ? sub_q :
                  sub_wrap ? 6'h00 : 6'(sub_q + 6'h01);
   assign bit_tick_d = !restart & gen_tick & sub_wrap;
   assign sample_tick_d = !restart & gen_tick & !is_sync &
                          (sub_q[1:0] == sbg_pkg::OVS_LAST);

   // fastest synchronous setting: no back-to-back characters
   assign fast_d = is_sync & (ps_sel == 2'h0) &
                   (bit_rate_divisor_q == 8'h00);

   sbg_brg u_brg (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .sel(ps_sel),
      .divisor(bit_rate_divisor_q),
      .restart(restart),
      .tick_q(gen_tick)
   );

   sbg_fifo #(
      .WIDTH(RXF_WIDTH),
      .DEPTH(RXF_DEPTH)
   ) u_rxf (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .in_valid(push),
      .in_ready(rxf_in_ready),
      .in_data({rx_mpb, rx_data}),
      .out_valid(rxf_out_valid),
      .out_ready(pop),
      .out_data(rxf_out_data),
      .level(rxf_level)
   );

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         serial_mode_reg_q <= sbg_pkg::MODE_RST;
         ctrl_q <= sbg_pkg::CTRL_RST;
         bit_rate_divisor_q <= sbg_pkg::DIV_RST;
      end
      else
      begin
         serial_mode_reg_q <= serial_mode_reg_d;
         ctrl_q <= ctrl_d;
         bit_rate_divisor_q <= bit_rate_divisor_d;
      end
   end

   // multiprocessor bit flags
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_multiproc_bit_q <= sbg_pkg::RXMP_RST;
         tx_multiproc_bit_q <= sbg_pkg::TXMP_RST;
      end
      else
      begin
         rx_multiproc_bit_q <= rx_multiproc_bit_d;
         tx_multiproc_bit_q <= tx_multiproc_bit_d;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         rxd_hit_q <= 1'b0;
      end
      else
      begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         rxd_hit_q <= rxd_hit_d;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_ready_q <= 1'b0;
         tx_mpb_q <= 1'b0;
         tx_mpb_used_q <= 1'b0;
      end
      else
      begin
         rx_ready_q <= rx_ready_d;
         tx_mpb_q <= tx_mpb_d;
         tx_mpb_used_q <= tx_mpb_used_d;
      end
   end

   // bit subdivision and tick pulses
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sub_q <= 6'h00;
         sample_tick_q <= 1'b0;
         bit_tick_q <= 1'b0;
      end
      else
      begin
         sub_q <= sub_d;
         sample_tick_q <= sample_tick_d;
         bit_tick_q <= bit_tick_d;
      end
   end

   // fastest-setting flag
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fast_q <= 1'b0;
      end
      else
      begin
         fast_q <= fast_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign rx_ready = rx_ready_q;
   assign tx_mpb = tx_mpb_q;
   assign tx_mpb_used = tx_mpb_used_q;
   assign sync_mode = serial_mode_reg_q[sbg_pkg::MODE_SYNC];
   assign multiproc_en = serial_mode_reg_q[sbg_pkg::MODE_MP];
   assign transmit_enable = ctrl_q[sbg_pkg::CTRL_TE];
   assign receive_enable = ctrl_q[sbg_pkg::CTRL_RE];
   assign brg_tick = gen_tick;
   assign sample_tick = sample_tick_q;
   assign bit_tick = bit_tick_q;
   assign cont_xfer_blocked = fast_q;
endmodule // sbg_baud_gen_mpb

// >>> design/sbg_brg.sv
/*
 * prescaler and divisor counter of the baud rate generator.
 * assumes select and divisor are register outputs in the same domain.
 */
module sbg_brg (
   input wire logic ref_clk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic [1:0] sel, // prescale code
   input wire logic [7:0] divisor, // divisor value
   input wire logic restart, // reload counters
   output logic tick_q // one tick per period
);
   logic [5:0] pre_q;
   logic [5:0] pre_d;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic tick_d;
   logic pre_en;
   logic cnt_zero;

   // 00 undivided, 01 /4, 10 /16, 11 /64
   assign pre_en = (sel == 2'h0) ? 1'b1 :
                   (sel == 2'h1) ? (pre_q[1:0] == 2'h3) :
                   (sel == 2'h2) ? (pre_q[3:0] == 4'hF) :
                   (pre_q == 6'h3F);
   assign cnt_zero = (cnt_q == 8'h00);
   assign pre_d = restart ? 6'h00 : 6'(pre_q + 6'h01);
   // reload on zero: divisor plus one prescaled cycles per tick
   assign cnt_d = restart ? divisor :
                  !pre_en ? cnt_q :
                  cnt_zero ? divisor : 8'(cnt_q - 8'h01);
   assign tick_d = !restart & pre_en & cnt_zero;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pre_q <= 6'h00;
         cnt_q <= sbg_pkg::DIV_RST;
         tick_q <= 1'b0;
      end
      else
      begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end
endmodule // sbg_brg

// >>> design/sbg_fifo.sv
/*
 * synchronous fifo with valid and ready on both sides.
 * assumes one clock; level is the word count held.
 */
module sbg_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic ref_clk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic in_valid, // write request
   output logic in_ready, // room for a word
   input wire logic [WIDTH-1:0] in_data, // write word
   output logic out_valid, // word available
   input wire logic out_ready, // read request
   output logic [WIDTH-1:0] out_data, // head word
   output logic [AW:0] level // words held
);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != FULL);
   assign out_valid = (cnt_q != '0);
   assign push = in_valid & in_ready;
   assign pop = out_ready & out_valid;
   assign out_data = mem[rd_q];
   assign level = cnt_q;

   always_ff @(posedge ref_clk)
   begin
      if (push)
         mem[wr_q] <= in_data;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == LAST) ? '0 : AW'(wr_q + 1'b1);
         if (pop)
            rd_q <= (rd_q == LAST) ? '0 : AW'(rd_q + 1'b1);
         cnt_q <= (AW+1)'(cnt_q + push - pop);
      end
   end
endmodule // sbg_fifo

// >>> tb/sbg_baud_gen_mpb_assertions.sv
/* checker for the baud generator and multiprocessor bit block.
   assumes one clock domain and attachment by the bind at the foot. */
module sbg_checker (
   input wire logic ref_clk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic rx_ready, // receive room
   input wire logic receive_enable, // receiver on
   input wire logic tx_mpb, // multiproc bit out
   input wire logic tx_mpb_used, // append enable
   input wire logic sync_mode, // synchronous mode
   input wire logic multiproc_en, // multiproc format
   input wire logic transmit_enable, // transmitter on
   input wire logic sample_tick, // oversample tick
   input wire logic bit_tick, // bit tick
   input wire logic cont_xfer_blocked // fastest sync flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   wire logic acc_wr = psel && penable && pwrite;
   chk_ready_answer:
      assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_single:
      assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_err_with_ready:
      assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_mpb_gated:
      assert property (tx_mpb |-> tx_mpb_used)
      else $error("multiproc bit sent while unused");
   chk_used_on:
      assert property ((!sync_mode && multiproc_en && transmit_enable)[*3]
         |-> tx_mpb_used)
      else $error("append not enabled");
   chk_sync_ignores:
      assert property (sync_mode[*3] |-> !tx_mpb && !tx_mpb_used)
      else $error("multiproc bit in sync mode");
   chk_mpb_write_only:
      assert property ($changed(tx_mpb) |-> $past(acc_wr) || $past(acc_wr, 2))
      else $error("multiproc bit changed without write");
   chk_fast_sync:
      assert property (cont_xfer_blocked |-> $past(sync_mode))
      else $error("fast flag outside sync mode");
   chk_no_sample_sync:
      assert property (sync_mode[*2] |-> !sample_tick)
      else $error("oversample tick in sync mode");
   chk_bit_spacing:
      assert property (bit_tick |=> !bit_tick[*7])
      else $error("bit ticks closer than eight cycles");
   chk_ready_needs_re:
      assert property (rx_ready |-> $past(receive_enable))
      else $error("receive room while receiver off");
endmodule // sbg_checker

bind sbg_baud_gen_mpb sbg_checker chk_u (.ref_clk, .nrst, .psel, .penable,
   .pwrite, .pready, .pslverr, .rx_ready, .receive_enable, .tx_mpb,
   .tx_mpb_used, .sync_mode, .multiproc_en, .transmit_enable, .sample_tick,
   .bit_tick, .cont_xfer_blocked);

// >>> tb/sbg_peer_model.sv
/* serial peer: offers received characters to the block.
   assumes the bench calls send and waits for its return. */
module sbg_peer_model (
   input wire logic ref_clk, // system clock
   input wire logic rx_ready, // block has room
   output logic rx_valid, // character offered
   output logic [7:0] rx_data, // character
   output logic rx_mpb // multiprocessor bit
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_mpb = 1'b0;
   end
   task automatic send(input logic [7:0] d, input logic m,
      input logic [1:0] gap, output bit ok);
      int n;
      repeat (gap) @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_data <= d;
      rx_mpb <= m;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (rx_ready !== 1'b1 && n < 40);
      ok = (rx_ready === 1'b1);
      // stale lines show the inverse, never the last value
      rx_valid <= 1'b0;
      rx_data <= ~d;
      rx_mpb <= ~m;
      @(posedge ref_clk);
   endtask
endmodule // sbg_peer_model

// >>> tb/test_serial_baud_gen_mpb.sv
/* self-checking bench for the baud generator block.
   assumes the checker bind and the peer model are compiled alongside. */
module test_serial_baud_gen_mpb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, lowpwr_enter = 1'b0;
   logic [7:0] paddr = 8'h00, rx_data;
   logic [31:0] pwdata = 32'h0000_0000, prdata, lf = 32'hb260;
   logic pready, pslverr, rx_valid, rx_ready, rx_mpb, tx_mpb, tx_mpb_used;
   logic sync_mode, multiproc_en, transmit_enable, receive_enable;
   logic brg_tick, sample_tick, bit_tick, cont_xfer_blocked;
   logic [32:0] exp_q[$], mon_e;
   logic [8:0] rxq[$], w;
   logic [7:0] mtab[4] = '{8'h84, 8'h00, 8'h04, 8'h04};
   logic [1:0] ctab[4] = '{2'h3, 2'h3, 2'h2, 2'h3};
   int err_total = 0, n_tests = 0, p;
   bit ok;

   sbg_baud_gen_mpb dut_u (.ref_clk, .nrst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .lowpwr_enter, .rx_valid,
      .rx_ready, .rx_data, .rx_mpb, .tx_mpb, .tx_mpb_used, .sync_mode,
      .multiproc_en, .transmit_enable, .receive_enable, .brg_tick,
      .sample_tick, .bit_tick, .cont_xfer_blocked);
   sbg_peer_model peer_u (.ref_clk, .rx_ready, .rx_valid, .rx_data,
      .rx_mpb);

   initial forever #2 ref_clk = ~ref_clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic tk(input int k);
      return k == 0 ? brg_tick : k == 1 ? sample_tick : bit_tick;
   endfunction

   task automatic tally_and_finish;
      if (err_total == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [32:0] e,
      input logic [32:0] g);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] e);
      int n;
      exp_q.push_back(e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         err_total++;
         tally_and_finish();
      end
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0_0000_0000);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000, {1'b0, e});
   endtask

   // cycles between two consecutive ticks of one kind
   task automatic period(input int k, output int q);
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (tk(k) !== 1'b1 && n < 5000);
      if (tk(k) !== 1'b1)
      begin
         err_total++;
         tally_and_finish();
      end
      q = 0;
      do
      begin
         @(posedge ref_clk);
         q++;
      end
      while (tk(k) !== 1'b1 && q < 5000);
      if (tk(k) !== 1'b1)
      begin
         err_total++;
         tally_and_finish();
      end
   endtask

   always @(posedge ref_clk)
      if (psel && penable && pready)
      begin
         mon_e = exp_q.pop_front();
         chk("pslverr", {32'h0, mon_e[32]}, {32'h0, pslverr});
         if (!pwrite)
            chk("prdata", {1'b0, mon_e[31:0]}, {1'b0, prdata});
      end

   initial
   begin
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      rd(sbg_pkg::MODE_OFS, 32'h0000_0000);
      rd(sbg_pkg::CTRL_OFS, 32'h0000_0000);
      rd(sbg_pkg::STAT_OFS, 32'h0000_0000);
      rd(sbg_pkg::DIV_OFS, 32'h0000_00ff);
      apb(1'b0, 8'h14, 32'h0000_0000, 33'h1_0000_0000);
      apb(1'b1, 8'h18, 32'h0000_005a, 33'h1_0000_0000);
      for (int i = 0; i < 4; i++)
      begin
         lf = lfsr(lf);
         wr(sbg_pkg::DIV_OFS, lf);
         rd(sbg_pkg::DIV_OFS, {24'h0, lf[7:0]});
      end
      lowpwr_enter <= 1'b1;
      @(posedge ref_clk);
      lowpwr_enter <= 1'b0;
      rd(sbg_pkg::DIV_OFS, 32'h0000_00ff);
      wr(sbg_pkg::DIV_OFS, 32'h0000_0002);
      for (int s = 0; s < 4; s++)
      begin
         wr(sbg_pkg::MODE_OFS, s);
         period(0, p);
         chk("brg_period", 3 << (2 * s), p);
      end
      wr(sbg_pkg::MODE_OFS, 32'h0000_0000);
      wr(sbg_pkg::DIV_OFS, 32'h0000_00ff);
      period(0, p);
      chk("brg_period_max", 256, p);
      wr(sbg_pkg::DIV_OFS, 32'h0000_0000);
      period(1, p);
      chk("sample_period", 4, p);
      period(2, p);
      chk("async_bit_period", 64, p);
      wr(sbg_pkg::MODE_OFS, 32'h0000_0080);
      wr(sbg_pkg::DIV_OFS, 32'h0000_0001);
      period(2, p);
      chk("sync_bit_period", 16, p);
      rd(sbg_pkg::STAT_OFS, 32'h0000_0000);
      wr(sbg_pkg::DIV_OFS, 32'h0000_0000);
      rd(sbg_pkg::STAT_OFS, 32'h0000_0008);
      chk("cont_blocked", 1, cont_xfer_blocked);
      wr(sbg_pkg::STAT_OFS, 32'h0000_0001);
      for (int i = 0; i < 4; i++)
      begin
         wr(sbg_pkg::MODE_OFS, mtab[i]);
         wr(sbg_pkg::CTRL_OFS, ctab[i]);
         repeat (2) @(posedge ref_clk);
         chk("tx_mpb", i == 3, tx_mpb);
         chk("tx_mpb_used", i == 3, tx_mpb_used);
         chk("sync", mtab[i][sbg_pkg::MODE_SYNC], sync_mode);
         chk("mp_en", mtab[i][sbg_pkg::MODE_MP], multiproc_en);
         chk("te", ctab[i][sbg_pkg::CTRL_TE], transmit_enable);
         chk("re", ctab[i][sbg_pkg::CTRL_RE], receive_enable);
      end
      for (int i = 0; i < 17; i++)
      begin
         lf = lfsr(lf);
         w = {(i == 15) | lf[8], lf[7:0]};
         peer_u.send(w[7:0], w[8], lf[10:9], ok);
         chk("accepted", i < 16, ok);
         if (ok)
            rxq.push_back(w);
      end
      rd(sbg_pkg::STAT_OFS, 32'h0000_0007);
      wr(sbg_pkg::STAT_OFS, 32'h0000_0002);
      rd(sbg_pkg::STAT_OFS, 32'h0000_0006);
      wr(sbg_pkg::CTRL_OFS, 32'h0000_0001);
      rd(sbg_pkg::STAT_OFS, 32'h0000_0006);
      while (rxq.size() > 0)
         rd(sbg_pkg::RXD_OFS, {23'h0, rxq.pop_front()});
      rd(sbg_pkg::RXD_OFS, 32'h0000_0000);
      rd(sbg_pkg::STAT_OFS, 32'h0000_0002);
      tally_and_finish();
   end
endmodule // test_serial_baud_gen_mpb
